// ### bench/afcs_source.sv
// analog source model for both frequency-setting terminals
`timescale 1ns/1ps
`default_nettype none
module afcs_source (
   input  wire logic        drop_i,
   input  wire logic [11:0] volt_set_i,
   input  wire logic [11:0] cur_set_i,
   output wire logic [11:0] volt_o,
   output wire logic [11:0] cur_o
);
   // ========
   // levels
   // a lost source reads as zero level
   assign volt_o = drop_i ? 12'h000 : volt_set_i;
   assign cur_o  = drop_i ? 12'h000 : cur_set_i;
endmodule
`default_nettype wire

// ### bench/afcs_top_bench.sv
// self-checking bench of the command scaler
`timescale 1ns/1ps
`default_nettype none
module afcs_top_bench
   import afcs_pkg::*;
;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cur_sel, start, running, panel, drop, wr, c_open, c_store, c_close;
   logic [1:0]  wsel;
   logic [3:0]  pid, cpt;
   logic [15:0] pdata, freq, rdata;
   logic [11:0] vset, cset, vadc, cadc;
   logic        fwd, rev, revbl, done, refused, cact;
   logic [12:0] live;
   int          num_errors = 0;
   int          samples_checked = 0;
   int          seed = 32'hecb2;
   logic [15:0] dflt [12] = '{16'h1, 16'h1, 16'h1388, 16'h1388, 16'h0, 16'h0, 16'h0, 16'h3e8, 16'h0, 16'hc8,
                               16'h3e8, 16'h0};
   always #25 clk_i = ~clk_i;
   afcs_top #(.TICK_CYCLES(4)) dut (.CLK_I(clk_i), .RST_I(rst_i), .VOLT_ADC_I(vadc), .CUR_ADC_I(cadc),
      .CUR_SEL_I(cur_sel), .START_I(start), .RUNNING_I(running), .PANEL_MODE_I(panel), .WRITE_SEL_I(wsel),
      .PARAM_WR_I(wr), .PARAM_ID_I(pid), .PARAM_DATA_I(pdata), .CAL_OPEN_I(c_open), .CAL_POINT_I(cpt),
      .CAL_STORE_I(c_store), .CAL_CLOSE_I(c_close), .FREQ_CMD_O(freq), .FORWARD_O(fwd), .REVERSE_O(rev),
      .REVERSIBLE_O(revbl), .PARAM_RDATA_O(rdata), .WR_DONE_O(done), .WR_REFUSED_O(refused),
      .CAL_ACTIVE_O(cact), .LIVE_DISP_O(live));
   afcs_source u_src (.drop_i(drop), .volt_set_i(vset), .cur_set_i(cset), .volt_o(vadc), .cur_o(cadc));
   // ========
   // helpers
   function automatic int fexp(input int p, input int bp, input int gp, input int bf, input int gf);
      if (gp == bp) return bf;
      return bf + (p - bp) * (gf - bf) / (gp - bp);
   endfunction
   function automatic int pct(input int code, input int fs);
      return code * fs / 4096;
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", samples_checked, num_errors);
      if (num_errors == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         num_errors++;
         $display("wrong value %0s: expected %0d seen %0d", what, e, g);
      end
   endtask
   task automatic wrp(input logic [3:0] id, input logic [15:0] d, input logic ok);
      @(negedge clk_i);
      pid = id;
      pdata = d;
      wr = 1'b1;
      @(negedge clk_i);
      wr = 1'b0;
      chk("write done", 16'(ok), 16'(done));
      chk("write refused", 16'(!ok), 16'(refused));
   endtask
   // opens a calibration point, checks the live level, then stores or closes
   task automatic cal(input logic [3:0] p, input logic [12:0] lv, input logic st);
      cpt = p;
      repeat (4) @(negedge clk_i);
      c_open = 1'b1;
      @(negedge clk_i);
      c_open = 1'b0;
      chk("cal open", 16'h0001, 16'(cact));
      chk("live level", 16'(lv), 16'(live));
      {c_store, c_close} = {st, !st};
      @(negedge clk_i);
      {c_store, c_close} = 2'b00;
      pid = p;
      @(negedge clk_i);
      chk("cal closed", 16'h0000, 16'(cact));
   endtask
   // waits for the magnitude, then checks direction
   task automatic settle(input int e);
      int m;
      int i;
      m = e < 0 ? -e : e;
      for (i = 0; i < 3000; i++) begin
         @(negedge clk_i);
         if (int'(freq) >= m - 30 && int'(freq) <= m + 30) break;
      end
      chk("freq", 16'(m), i < 3000 ? 16'(m) : freq);
      if (i == 3000) finish_test();
      chk("reverse", 16'(e < 0), 16'(rev));
      chk("forward", 16'(e >= 0), 16'(fwd));
   endtask
   // ========
   // main sequence
   initial begin
      int k;
      int c;
      {cur_sel, running, drop, wr, c_open, c_store, c_close, start, panel} = 9'h003;
      {wsel, pid, cpt, pdata, vset, cset} = {2'h2, 48'h0};
      repeat (5) @(negedge clk_i);
      rst_i = 1'b0;
      for (k = 0; k < 12; k++) begin
         pid = 4'(k);
         repeat (2) @(negedge clk_i);
         chk("default", dflt[k], rdata);
      end
      $display("test defaults finished");
      wsel = WSEL_LOCKED;
      wrp(4'h2, 16'h0fa0, 1'b0);
      wrp(4'h4, 16'h0001, 1'b1);
      {wsel, running} = {WSEL_STOP, 1'b1};
      wrp(4'h2, 16'h0fa0, 1'b0);
      wrp(4'h4, 16'h0000, 1'b1);
      {wsel, running} = {WSEL_ANY, 1'b0};
      wrp(4'h2, 16'h9c41, 1'b0);
      wrp(4'h7, 16'h0bb9, 1'b0);
      wrp(4'h7, 16'h0bb8, 1'b1);
      wrp(4'h7, 16'h03e8, 1'b1);
      wrp(4'h4, 16'h0000, 1'b1);
      $display("test writes finished");
      wrp(4'h1, 16'h0008, 1'b1);
      vset = 12'hfff;
      repeat (200) @(negedge clk_i);
      chk("slow filter", 16'h0001, 16'(freq < 16'h1388));
      wrp(4'h1, 16'h0000, 1'b1);
      settle(fexp(pct(4095, 2000), 0, 1000, 0, 5000));
      for (k = 0; k < 6; k++) begin
         c = $random(seed) & 32'h0fff;
         vset = 12'(c);
         settle(fexp(pct(c, 2000), 0, 1000, 0, 5000));
      end
      wrp(4'h2, 16'h0fa0, 1'b1);
      vset = 12'h800;
      settle(fexp(1000, 0, 1000, 0, 4000));
      wrp(4'h2, 16'h1388, 1'b1);
      $display("test scaling finished");
      wrp(4'h6, 16'h01f4, 1'b1);
      drop = 1'b1;
      settle(0);
      wrp(4'h0, 16'h000b, 1'b1);
      settle(-5000);
      chk("reversible", 16'h0001, 16'(revbl));
      drop = 1'b0;
      vset = 12'h333;
      settle(fexp(pct(819, 2000), 500, 1000, 0, 5000));
      vset = 12'hbb8;
      settle(fexp(pct(3000, 2000), 500, 1000, 0, 5000));
      cur_sel = 1'b1;
      settle(fexp(0, 200, 1000, 0, 5000));
      cset = 12'hfff;
      settle(fexp(pct(4095, 1000), 200, 1000, 0, 5000));
      cur_sel = 1'b0;
      wrp(4'h0, 16'h000a, 1'b1);
      settle(fexp(pct(3000, 1000), 500, 1000, 0, 5000));
      wrp(4'h0, 16'h000b, 1'b1);
      $display("test reversible finished");
      vset = 12'h600;
      cal(4'h7, 13'h02ee, 1'b1);
      chk("stored gain", 16'h02ee, rdata);
      wrp(4'h4, 16'h0001, 1'b1);
      repeat (2) @(negedge clk_i);
      chk("live volts", 16'h0177, 16'(live));
      wrp(4'hb, 16'h0001, 1'b1);
      cset = 12'h600;
      cal(4'ha, 13'h0177, 1'b0);
      chk("kept cur gain", 16'h03e8, rdata);
      cal(4'ha, 13'h0177, 1'b1);
      chk("stored cur gain", 16'h02ee, rdata);
      $display("test calibration finished");
      finish_test();
   end
endmodule
bind afcs_top afcs_top_properties u_props (.*);
`default_nettype wire

// ### bench/afcs_top_properties.sv
// port checks of the command scaler
`timescale 1ns/1ps
`default_nettype none
module afcs_top_properties
   import afcs_pkg::*;
(
   input wire logic        CLK_I,
   input wire logic        RST_I,
   input wire logic [1:0]  WRITE_SEL_I,
   input wire logic        RUNNING_I,
   input wire logic        PANEL_MODE_I,
   input wire logic        PARAM_WR_I,
   input wire logic [3:0]  PARAM_ID_I,
   input wire logic [15:0] PARAM_DATA_I,
   input wire logic        CAL_OPEN_I,
   input wire logic [3:0]  CAL_POINT_I,
   input wire logic        CAL_STORE_I,
   input wire logic        CAL_CLOSE_I,
   input wire logic        FORWARD_O,
   input wire logic        REVERSE_O,
   input wire logic        REVERSIBLE_O,
   input wire logic        WR_DONE_O,
   input wire logic        WR_REFUSED_O,
   input wire logic        CAL_ACTIVE_O
);
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);
   // ========
   // write port
   sequence s_take; PARAM_WR_I; endsequence
   sequence s_ans; WR_DONE_O ^ WR_REFUSED_O; endsequence
   property p_answer; s_take |=> s_ans; endproperty
   a_answer: assert property (p_answer) else $error("write answer missing");
   property p_unit; PARAM_WR_I && PARAM_ID_I == 4'h4 && PARAM_DATA_I <= 16'h0001 |=> WR_DONE_O; endproperty
   a_unit: assert property (p_unit) else $error("unit write refused");
   property p_lock; PARAM_WR_I && WRITE_SEL_I == WSEL_LOCKED && PARAM_ID_I != 4'h4 |=> WR_REFUSED_O; endproperty
   a_lock: assert property (p_lock) else $error("locked write taken");
   property p_frng; PARAM_WR_I && PARAM_ID_I == 4'h2 && PARAM_DATA_I > 16'h9c40 |=> WR_REFUSED_O; endproperty
   a_frng: assert property (p_frng) else $error("gain freq range");
   property p_prng; PARAM_WR_I && PARAM_ID_I == 4'h7 && PARAM_DATA_I > 16'h0bb8 |=> WR_REFUSED_O; endproperty
   a_prng: assert property (p_prng) else $error("percent range");
   // ========
   // direction and calibration
   property p_rev; REVERSE_O |-> REVERSIBLE_O && !FORWARD_O; endproperty
   a_rev: assert property (p_rev) else $error("reverse without reversible");
   property p_open; CAL_OPEN_I && !RUNNING_I && PANEL_MODE_I && CAL_POINT_I == 4'h7 |=> CAL_ACTIVE_O; endproperty
   a_open: assert property (p_open) else $error("cal not opened");
   property p_end; CAL_ACTIVE_O && CAL_STORE_I && !RUNNING_I && WRITE_SEL_I != WSEL_LOCKED |=> !CAL_ACTIVE_O; endproperty
   a_end: assert property (p_end) else $error("cal not closed");
endmodule
`default_nettype wire

// ### hdl/afcs_lag_filter.sv
// first-order lag filter on an input percentage
`timescale 1ns/1ps
`default_nettype none
module afcs_lag_filter
   import afcs_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              tick_i,
   input  wire logic [3:0]        setting_i,
   input  wire logic [PCT_W-1:0]  x_i,
   output logic      [PCT_W-1:0]  y_o
);

   // ==========================================================
   // shift per setting: time constant 4..4096 ticks of 250 us
   function automatic logic [3:0] shift_of(input logic [3:0] s);
      case (s)
         4'h0:    shift_of = 4'h2;
         4'h1:    shift_of = 4'h3;
         4'h2:    shift_of = 4'h4;
         4'h3:    shift_of = 4'h6;
         4'h4:    shift_of = 4'h7;
         4'h5:    shift_of = 4'h8;
         4'h6:    shift_of = 4'h9;
         4'h7:    shift_of = 4'ha;
         default: shift_of = 4'hc;
      endcase
   endfunction

   logic        [PCT_W+FRAC_W-1:0] acc_r;
   logic signed [PCT_W+FRAC_W:0]   diff;
   logic signed [PCT_W+FRAC_W:0]   step;

   assign diff = $signed({1'b0, x_i, {FRAC_W{1'b0}}}) - $signed({1'b0, acc_r});
   assign step = diff >>> shift_of(setting_i);

   // ==========================================================
   // accumulator
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_r <= '0;
      end else if (tick_i) begin
         acc_r <= (PCT_W+FRAC_W)'($signed({1'b0, acc_r}) + step);
      end
   end

   assign y_o = acc_r[PCT_W+FRAC_W-1:FRAC_W];

endmodule
`default_nettype wire

// ### hdl/afcs_pkg.sv
// constants and types shared by the analog frequency command scaler
package afcs_pkg;

   // ==========================================================
   // clock and filter timing
   localparam int CLK_HZ       = 20_000_000;
   localparam int TICK_US      = 250;
   localparam int TICK_CYC     = (CLK_HZ / 1_000_000) * TICK_US;

   // ==========================================================
   // widths and scales (freq in 0.01 Hz, percent in 0.1 %)
   localparam int ADC_W        = 12;
   localparam int PCT_W        = 12;
   localparam int FREQ_W       = 16;
   localparam int DISP_W       = 13;
   localparam int FRAC_W       = 12;
   localparam logic [15:0] FREQ_MAX     = 16'h9c40;
   localparam logic [11:0] PCT_MAX      = 12'hbb8;
   localparam logic [11:0] PCT_FULL     = 12'h3e8;
   localparam logic [11:0] PCT_DBL      = 12'h7d0;
   localparam logic [11:0] FS_5V        = 12'h1f4;
   localparam logic [11:0] FS_10V       = 12'h3e8;
   localparam logic [11:0] FS_20MA      = 12'h7d0;

   // ==========================================================
   // setting codes
   localparam logic [3:0] AIN_10V       = 4'h0;
   localparam logic [3:0] AIN_5V        = 4'h1;
   localparam logic [3:0] AIN_10V_REV   = 4'ha;
   localparam logic [3:0] AIN_5V_REV    = 4'hb;
   localparam logic [1:0] CTYPE_4_20MA  = 2'h0;
   localparam logic [1:0] CTYPE_5V      = 2'h1;
   localparam logic [1:0] CTYPE_10V     = 2'h2;
   localparam logic [3:0] FILT_MAX      = 4'h8;
   localparam logic [1:0] WSEL_STOP     = 2'h0;
   localparam logic [1:0] WSEL_LOCKED   = 2'h1;
   localparam logic [1:0] WSEL_ANY      = 2'h2;

   // ==========================================================
   // reset values
   localparam logic [3:0]  AIN_SEL_RST    = 4'h1;
   localparam logic [3:0]  FILT_RST       = 4'h1;
   localparam logic [1:0]  CTYPE_RST      = 2'h0;
   localparam logic        DISP_UNIT_RST  = 1'b0;
   localparam logic [15:0] VGAIN_FREQ_RST = 16'h1388;
   localparam logic [15:0] CGAIN_FREQ_RST = 16'h1388;
   localparam logic [15:0] VBIAS_FREQ_RST = 16'h0000;
   localparam logic [15:0] CBIAS_FREQ_RST = 16'h0000;
   localparam logic [11:0] VBIAS_PCT_RST  = 12'h000;
   localparam logic [11:0] VGAIN_PCT_RST  = 12'h3e8;
   localparam logic [11:0] CBIAS_PCT_RST  = 12'h0c8;
   localparam logic [11:0] CGAIN_PCT_RST  = 12'h3e8;

   // ==========================================================
   // parameter identifiers on the panel write port
   typedef enum logic [3:0] {
      P_AIN_SEL    = 4'h0,
      P_FILT       = 4'h1,
      P_VGAIN_FREQ = 4'h2,
      P_CGAIN_FREQ = 4'h3,
      P_DISP_UNIT  = 4'h4,
      P_VBIAS_FREQ = 4'h5,
      P_VBIAS_PCT  = 4'h6,
      P_VGAIN_PCT  = 4'h7,
      P_CBIAS_FREQ = 4'h8,
      P_CBIAS_PCT  = 4'h9,
      P_CGAIN_PCT  = 4'ha,
      P_CTYPE      = 4'hb
   } afcs_param_type;

   typedef enum logic {
      CAL_IDLE = 1'b0,
      CAL_EDIT = 1'b1
   } afcs_cal_type;

endpackage

// ### hdl/afcs_top.sv
// analog frequency command scaler: filter, bias/gain scaling, direction
//
// What this block does
// - reversible only with input selection 10 or 11
// - 5 V reversible: low half reverse, high forward
// - default current reversible: below 4 mA reverse
// - missing input plus start gives reverse
// - lag filter on both inputs, setting 0..8
// - time constant about 1 ms to 1 s
// - voltage gain frequency, default 50 Hz, 0..400
// - current gain frequency, default 50 Hz
// - bias/gain percents 0..300, gains default 100
// - voltage bias frequency 0 Hz at 0 V
// - current bias point defaults to 20 percent
// - gain frequency alone rescales the maximum
// - display unit: percent or volts/milliamps
// - display unit writable at any time
// - calibration shows live level, stores on confirm
// - voltage range 0..5 V or 0..10 V
// - current terminal type 4-20 mA, 5 V, 10 V
`timescale 1ns/1ps
`default_nettype none
module afcs_top
   import afcs_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYC
)(
   input  wire logic              CLK_I,
   input  wire logic              RST_I,
   input  wire logic [ADC_W-1:0]  VOLT_ADC_I,
   input  wire logic [ADC_W-1:0]  CUR_ADC_I,
   input  wire logic              CUR_SEL_I,
   input  wire logic              START_I,
   input  wire logic              RUNNING_I,
   input  wire logic              PANEL_MODE_I,
   input  wire logic [1:0]        WRITE_SEL_I,
   input  wire logic              PARAM_WR_I,
   input  wire logic [3:0]        PARAM_ID_I,
   input  wire logic [15:0]       PARAM_DATA_I,
   input  wire logic              CAL_OPEN_I,
   input  wire logic [3:0]        CAL_POINT_I,
   input  wire logic              CAL_STORE_I,
   input  wire logic              CAL_CLOSE_I,
   output logic      [FREQ_W-1:0] FREQ_CMD_O,
   output logic                   FORWARD_O,
   output logic                   REVERSE_O,
   output logic                   REVERSIBLE_O,
   output logic      [15:0]       PARAM_RDATA_O,
   output logic                   WR_DONE_O,
   output logic                   WR_REFUSED_O,
   output logic                   CAL_ACTIVE_O,
   output logic      [DISP_W-1:0] LIVE_DISP_O
);

   // ==========================================================
   // helpers
   function automatic logic [PCT_W-1:0] pct_of(input logic [ADC_W-1:0] code, input logic half);
      logic [23:0] p;
      p = {12'h000, code} * {12'h000, (half ? PCT_DBL : PCT_FULL)};
      return p[23:12];
   endfunction

   function automatic logic [DISP_W-1:0] disp_of(input logic [PCT_W-1:0] pct,
                                                 input logic [11:0] fs, input logic unit);
      logic [23:0] p;
      p = {12'h000, pct} * {12'h000, fs};
      if (!unit) begin
         return {1'b0, pct};
      end
      return DISP_W'(p / 24'(PCT_FULL));
   endfunction

   // ==========================================================
   // input synchronisers
   logic [ADC_W-1:0] volt_m_r;
   logic [ADC_W-1:0] volt_s_r;
   logic [ADC_W-1:0] cur_m_r;
   logic [ADC_W-1:0] cur_s_r;
   logic [1:0]       pin_m_r;
   logic [1:0]       pin_s_r;
   logic             cur_sel;
   logic             start;

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         volt_m_r <= '0;
         volt_s_r <= '0;
         cur_m_r  <= '0;
         cur_s_r  <= '0;
         pin_m_r  <= '0;
         pin_s_r  <= '0;
      end else begin
         volt_m_r <= VOLT_ADC_I;
         volt_s_r <= volt_m_r;
         cur_m_r  <= CUR_ADC_I;
         cur_s_r  <= cur_m_r;
         pin_m_r  <= {START_I, CUR_SEL_I};
         pin_s_r  <= pin_m_r;
      end
   end

   assign cur_sel = pin_s_r[0];
   assign start   = pin_s_r[1];

   // ==========================================================
   // settings
   logic [3:0]        ain_sel_r;
   logic [3:0]        filt_r;
   logic [1:0]        ctype_r;
   logic              disp_unit_r;
   logic [15:0]       vgain_f_r;
   logic [15:0]       cgain_f_r;
   logic [15:0]       vbias_f_r;
   logic [15:0]       cbias_f_r;
   logic [PCT_W-1:0]  vbias_p_r;
   logic [PCT_W-1:0]  vgain_p_r;
   logic [PCT_W-1:0]  cbias_p_r;
   logic [PCT_W-1:0]  cgain_p_r;
   logic              wr_ok;
   logic              in_range;
   logic              store_ok;
   logic [PCT_W-1:0]  live_pct;

   always_comb begin
      case (afcs_param_type'(PARAM_ID_I))
         P_AIN_SEL:    in_range = (PARAM_DATA_I == 16'(AIN_10V)) || (PARAM_DATA_I == 16'(AIN_5V)) ||
                                  (PARAM_DATA_I == 16'(AIN_10V_REV)) || (PARAM_DATA_I == 16'(AIN_5V_REV));
         P_FILT:       in_range = PARAM_DATA_I <= 16'(FILT_MAX);
         P_CTYPE:      in_range = PARAM_DATA_I <= 16'(CTYPE_10V);
         P_DISP_UNIT:  in_range = PARAM_DATA_I <= 16'h0001;
         P_VGAIN_FREQ,
         P_CGAIN_FREQ,
         P_VBIAS_FREQ,
         P_CBIAS_FREQ: in_range = PARAM_DATA_I <= FREQ_MAX;
         P_VBIAS_PCT,
         P_VGAIN_PCT,
         P_CBIAS_PCT,
         P_CGAIN_PCT:  in_range = PARAM_DATA_I <= 16'(PCT_MAX);
         default:      in_range = 1'b0;
      endcase
   end

   // display unit is exempt from the write lock
   assign wr_ok = PARAM_WR_I && in_range &&
                  ((PARAM_ID_I == P_DISP_UNIT) ||
                   (WRITE_SEL_I == WSEL_ANY) ||
                   ((WRITE_SEL_I == WSEL_STOP) && !RUNNING_I));

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         ain_sel_r   <= AIN_SEL_RST;
         filt_r      <= FILT_RST;
         ctype_r     <= CTYPE_RST;
         disp_unit_r <= DISP_UNIT_RST;
         vgain_f_r   <= VGAIN_FREQ_RST;
         cgain_f_r   <= CGAIN_FREQ_RST;
         vbias_f_r   <= VBIAS_FREQ_RST;
         cbias_f_r   <= CBIAS_FREQ_RST;
         vbias_p_r   <= VBIAS_PCT_RST;
         vgain_p_r   <= VGAIN_PCT_RST;
         cbias_p_r   <= CBIAS_PCT_RST;
         cgain_p_r   <= CGAIN_PCT_RST;
      end else if (wr_ok) begin
         case (afcs_param_type'(PARAM_ID_I))
            P_AIN_SEL:    ain_sel_r   <= PARAM_DATA_I[3:0];
            P_FILT:       filt_r      <= PARAM_DATA_I[3:0];
            P_CTYPE:      ctype_r     <= PARAM_DATA_I[1:0];
            P_DISP_UNIT:  disp_unit_r <= PARAM_DATA_I[0];
            P_VGAIN_FREQ: vgain_f_r   <= PARAM_DATA_I;
            P_CGAIN_FREQ: cgain_f_r   <= PARAM_DATA_I;
            P_VBIAS_FREQ: vbias_f_r   <= PARAM_DATA_I;
            P_CBIAS_FREQ: cbias_f_r   <= PARAM_DATA_I;
            P_VBIAS_PCT:  vbias_p_r   <= PARAM_DATA_I[PCT_W-1:0];
            P_VGAIN_PCT:  vgain_p_r   <= PARAM_DATA_I[PCT_W-1:0];
            P_CBIAS_PCT:  cbias_p_r   <= PARAM_DATA_I[PCT_W-1:0];
            P_CGAIN_PCT:  cgain_p_r   <= PARAM_DATA_I[PCT_W-1:0];
            default:      ain_sel_r   <= ain_sel_r;
         endcase
      end else if (store_ok) begin
         case (afcs_param_type'(CAL_POINT_I))
            P_VBIAS_PCT:  vbias_p_r   <= live_pct;
            P_VGAIN_PCT:  vgain_p_r   <= live_pct;
            P_CBIAS_PCT:  cbias_p_r   <= live_pct;
            P_CGAIN_PCT:  cgain_p_r   <= live_pct;
            default:      ain_sel_r   <= ain_sel_r;
         endcase
      end
   end

   // ==========================================================
   // write answer and read-back
   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         WR_DONE_O    <= 1'b0;
         WR_REFUSED_O <= 1'b0;
      end else begin
         WR_DONE_O    <= wr_ok;
         WR_REFUSED_O <= PARAM_WR_I && !wr_ok;
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         PARAM_RDATA_O <= '0;
      end else begin
         case (afcs_param_type'(PARAM_ID_I))
            P_AIN_SEL:    PARAM_RDATA_O <= 16'(ain_sel_r);
            P_FILT:       PARAM_RDATA_O <= 16'(filt_r);
            P_CTYPE:      PARAM_RDATA_O <= 16'(ctype_r);
            P_DISP_UNIT:  PARAM_RDATA_O <= 16'(disp_unit_r);
            P_VGAIN_FREQ: PARAM_RDATA_O <= vgain_f_r;
            P_CGAIN_FREQ: PARAM_RDATA_O <= cgain_f_r;
            P_VBIAS_FREQ: PARAM_RDATA_O <= vbias_f_r;
            P_CBIAS_FREQ: PARAM_RDATA_O <= cbias_f_r;
            P_VBIAS_PCT:  PARAM_RDATA_O <= 16'(vbias_p_r);
            P_VGAIN_PCT:  PARAM_RDATA_O <= 16'(vgain_p_r);
            P_CBIAS_PCT:  PARAM_RDATA_O <= 16'(cbias_p_r);
            P_CGAIN_PCT:  PARAM_RDATA_O <= 16'(cgain_p_r);
            default:      PARAM_RDATA_O <= '0;
         endcase
      end
   end

   // ==========================================================
   // scaling of inputs to percent of the selected range
   logic             v_half;
   logic             c_half;
   logic             rev_en;
   logic [PCT_W-1:0] v_pct;
   logic [PCT_W-1:0] c_pct;
   logic [PCT_W-1:0] v_filt;
   logic [PCT_W-1:0] c_filt;
   logic [11:0]      v_fs;
   logic [11:0]      c_fs;

   assign v_half = (ain_sel_r == AIN_5V) || (ain_sel_r == AIN_5V_REV);
   assign c_half = (ctype_r == CTYPE_5V);
   assign v_fs   = v_half ? FS_5V : FS_10V;
   assign c_fs   = (ctype_r == CTYPE_4_20MA) ? FS_20MA : (c_half ? FS_5V : FS_10V);
   assign v_pct  = pct_of(volt_s_r, v_half);
   assign c_pct  = pct_of(cur_s_r, c_half);
   assign rev_en = (ain_sel_r == AIN_10V_REV) || (ain_sel_r == AIN_5V_REV);

   // ==========================================================
   // filter tick and filters
   logic [15:0] tick_cnt_r;
   logic        tick;

   assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         tick_cnt_r <= '0;
      end else begin
         tick_cnt_r <= tick ? 16'h0000 : tick_cnt_r + 16'h0001;
      end
   end

   afcs_lag_filter u_volt_filt (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .tick_i    (tick),
      .setting_i (filt_r),
      .x_i       (v_pct),
      .y_o       (v_filt)
   );

   afcs_lag_filter u_cur_filt (
      .clk_i     (CLK_I),
      .rst_i     (RST_I),
      .tick_i    (tick),
      .setting_i (filt_r),
      .x_i       (c_pct),
      .y_o       (c_filt)
   );

   // ==========================================================
   // calibration with an applied input
   afcs_cal_type cal_r;
   logic         cal_cur;
   logic         cal_pt_ok;

   assign cal_pt_ok = (CAL_POINT_I == P_VBIAS_PCT) || (CAL_POINT_I == P_VGAIN_PCT) ||
                      (CAL_POINT_I == P_CBIAS_PCT) || (CAL_POINT_I == P_CGAIN_PCT);
   assign cal_cur   = (CAL_POINT_I == P_CBIAS_PCT) || (CAL_POINT_I == P_CGAIN_PCT);
   assign live_pct  = cal_cur ? c_pct : v_pct;
   assign store_ok  = (cal_r == CAL_EDIT) && CAL_STORE_I && cal_pt_ok && !RUNNING_I && (WRITE_SEL_I != WSEL_LOCKED);

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         cal_r <= CAL_IDLE;
      end else begin
         case (cal_r)
            CAL_IDLE: if (CAL_OPEN_I && cal_pt_ok && !RUNNING_I && PANEL_MODE_I) begin
               cal_r <= CAL_EDIT;
            end
            CAL_EDIT: if (CAL_CLOSE_I || store_ok || RUNNING_I || !PANEL_MODE_I) begin
               cal_r <= CAL_IDLE;
            end
            default:  cal_r <= CAL_IDLE;
         endcase
      end
   end

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         LIVE_DISP_O <= '0;
      end else begin
         LIVE_DISP_O <= disp_of(live_pct, cal_cur ? c_fs : v_fs, disp_unit_r);
      end
   end

   assign CAL_ACTIVE_O = (cal_r == CAL_EDIT);

   // ==========================================================
   // interpolation through bias and gain points
   logic [PCT_W-1:0]  pct;
   logic [15:0]       bf;
   logic [15:0]       gf;
   logic [PCT_W-1:0]  bp;
   logic [PCT_W-1:0]  gp;
   logic signed [13:0] dp;
   logic signed [13:0] dg;
   logic signed [17:0] df;
   logic signed [31:0] prod;
   logic signed [31:0] res;
   logic               neg;
   logic [31:0]        mag;
   logic [FREQ_W-1:0]  mag_c;

   always_comb begin
      if (cur_sel) begin
         pct = c_filt;
         bf  = cbias_f_r;
         gf  = cgain_f_r;
         bp  = cbias_p_r;
         gp  = cgain_p_r;
      end else begin
         pct = v_filt;
         bf  = vbias_f_r;
         gf  = vgain_f_r;
         bp  = vbias_p_r;
         gp  = vgain_p_r;
      end
   end

   assign dp   = $signed({2'b00, pct}) - $signed({2'b00, bp});
   assign dg   = $signed({2'b00, gp}) - $signed({2'b00, bp});
   assign df   = $signed({2'b00, gf}) - $signed({2'b00, bf});
   assign prod = 32'(dp * df);
   // equal points give a flat line at the bias frequency
   assign res  = (dg == 14'sd0) ? $signed({16'h0000, bf}) :
                 (prod / 32'(dg)) + $signed({16'h0000, bf});
   assign neg  = res < 32'sd0;
   assign mag  = neg ? 32'(-res) : 32'(res);
   assign mag_c = (mag > 32'(FREQ_MAX)) ? FREQ_MAX : mag[FREQ_W-1:0];

   always_ff @(posedge CLK_I or posedge RST_I) begin
      if (RST_I) begin
         FREQ_CMD_O   <= '0;
         FORWARD_O    <= 1'b0;
         REVERSE_O    <= 1'b0;
         REVERSIBLE_O <= 1'b0;
      end else begin
         REVERSIBLE_O <= rev_en;
         if (neg && !rev_en) begin
            FREQ_CMD_O <= '0;
         end else begin
            FREQ_CMD_O <= mag_c;
         end
         // a negative interpolated frequency in reversible mode runs backwards
         REVERSE_O <= start && rev_en && neg;
         FORWARD_O <= start && !(rev_en && neg);
      end
   end

endmodule
`default_nettype wire
